// *** mtp_pkg.sv ***
// Shared constants and types for the message port
package mtp_pkg;

    // ****************************************
    // Bus shape
    // ****************************************
    localparam int          BYTE_W    = 8;                // Width of one character
    localparam int          LANES     = 4;                // Byte lanes on the data bus
    localparam int          DATA_W    = BYTE_W * LANES;   // External data bus width
    localparam int          CS_LINE   = 2;                // Chip select line of this port
    localparam logic [31:0] ADDR_LO   = 32'h0200_0000;    // First decoded byte address
    localparam logic [31:0] ADDR_HI   = 32'h02FF_FFFF;    // Last decoded byte address
    localparam logic [3:0]  STRB_IDLE = 4'hF;             // All strobes and selects released

    // ****************************************
    // Buffering
    // ****************************************
    localparam int BUF_DEPTH  = 80;                       // Message buffer entries
    localparam int FIFO_DEPTH = 4;                        // Capture FIFO words

    // ****************************************
    // Character codes
    // ****************************************
    localparam logic [7:0] CHR_EXIT = 8'h04;              // Control D, end of test
    localparam logic [7:0] CHR_LF   = 8'h0A;              // Line feed, print
    localparam logic [7:0] CHR_CR   = 8'h0D;              // Carriage return, print
    localparam logic [7:0] CHR_LO   = 8'h20;              // Lowest stored character
    localparam logic [7:0] CHR_HI   = 8'h7E;              // Highest stored character

    // ****************************************
    // Message engine states
    // ****************************************
    typedef enum logic [0:0] {
        MTP_ST_IDLE,                                      // Collecting characters
        MTP_ST_EMIT                                       // Streaming the buffer out
    } mtp_state_type;

endpackage : mtp_pkg

// *** mtp_fifo.sv ***
// Small flop-based FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module mtp_fifo #(
    parameter int WIDTH = 8,                          // Word width
    parameter int DEPTH = 4                           // Number of words
) (
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    // ****************************************
    // Elaboration check
    // ****************************************
    if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
        $error("mtp_fifo needs DEPTH of at least 2 and WIDTH of at least 1");
    end

    localparam int PW = $clog2(DEPTH);                // Pointer width
    localparam int CW = $clog2(DEPTH + 1);            // Fill count width
    localparam logic [PW-1:0] LAST  = PW'(DEPTH - 1); // Last slot index
    localparam logic [CW-1:0] FULLC = CW'(DEPTH);     // Count when full

    logic [WIDTH-1:0] mem_q [DEPTH];                  // Storage slots
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [PW-1:0]    wr_q, wr_d;                     // Write pointer
    logic [PW-1:0]    rd_q, rd_d;                     // Read pointer
    logic [CW-1:0]    cnt_q, cnt_d;                   // Words held
    logic             push;
    logic             pop;

    // Honest flags straight from the fill count
    assign in_ready  = (cnt_q != FULLC);
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // ****************************************
    // Next state
    // ****************************************
    // Pointers wrap explicitly so depths that are not a power of two work
    always_comb begin
        mem_d = mem_q;
        wr_d  = wr_q;
        rd_d  = rd_q;
        cnt_d = cnt_q;
        if (push) begin
            mem_d[wr_q] = in_data;
            wr_d        = (wr_q == LAST) ? '0 : PW'(wr_q + 1'b1);
        end
        if (pop) begin
            rd_d = (rd_q == LAST) ? '0 : PW'(rd_q + 1'b1);
        end
        if (push && !pop) begin
            cnt_d = CW'(cnt_q + 1'b1);
        end else if (pop && !push) begin
            cnt_d = CW'(cnt_q - 1'b1);
        end
    end

    // Registers
    always_ff @(posedge clock) begin
        if (reset) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
            mem_q <= mem_d;
        end
    end

endmodule : mtp_fifo

`default_nettype wire

// *** mtp_message_port.sv ***
// Write-only character message port on the external static memory bus
// Operation
// - Capture data on own writes, never drive
// - Chip selects active low
// - Byte write strobes active low
// - Strobe 0 is low byte, 3 high
// - Decode own window by chip select two
// - Buffer 80 characters, emit on terminator/full
// - Emitted text goes to display output
// - Act only on codes 04, 10, 13
// - Exit code on empty buffer flags failure
// - Store other printable characters until emission
`timescale 1ns/1ps
`default_nettype none

module mtp_message_port
    import mtp_pkg::*;
#(
    parameter int DEPTH = BUF_DEPTH,                  // Message buffer entries
    parameter int FDEPTH = FIFO_DEPTH                 // Capture FIFO words
) (
    input  wire logic              clock,
    input  wire logic              reset,
    input  wire logic [DATA_W-1:0] ext_data_bus,
    input  wire logic [LANES-1:0]  ext_chip_sel_n,
    input  wire logic [LANES-1:0]  ext_byte_wr_n,
    output logic                   out_char_valid,
    output logic      [BYTE_W-1:0] out_char,
    output logic                   msg_done,
    output logic      [6:0]        msg_len,
    output logic                   exit_fail
);

    // ****************************************
    // Elaboration check
    // ****************************************
    if (DEPTH < 1 || DEPTH > 127) begin : g_bad_depth
        $error("mtp_message_port DEPTH must lie in 1..127");
    end

    localparam int          CW    = 7;                // Count width, fits msg_len
    localparam logic [CW-1:0] LASTC = CW'(DEPTH - 1); // Count before the last slot

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [DATA_W-1:0] data_s1_q, data_s2_q;          // Data bus stages
    logic [LANES-1:0]  cs_s1_q, cs_s2_q;              // Chip select stages
    logic [LANES-1:0]  wr_s1_q, wr_s2_q;              // Write strobe stages
    logic              wr_prev_q, wr_prev_d;          // Selected write, last cycle
    logic              sel_wr;                        // Selected write now
    logic              cap_stb;                       // Leading edge of a write
    logic [BYTE_W-1:0] cap_byte;                      // Byte from the active lane

    // Two flops per pin; only the second stage feeds logic
    always_ff @(posedge clock) begin
        if (reset) begin
            data_s1_q <= '0;
            data_s2_q <= '0;
            cs_s1_q   <= STRB_IDLE;
            cs_s2_q   <= STRB_IDLE;
            wr_s1_q   <= STRB_IDLE;
            wr_s2_q   <= STRB_IDLE;
        end else begin
            data_s1_q <= ext_data_bus;
            data_s2_q <= data_s1_q;
            cs_s1_q   <= ext_chip_sel_n;
            cs_s2_q   <= cs_s1_q;
            wr_s1_q   <= ext_byte_wr_n;
            wr_s2_q   <= wr_s1_q;
        end
    end

    // Only chip select two marks this window; other lines belong to other slaves
    assign sel_wr  = !cs_s2_q[CS_LINE] && (wr_s2_q != STRB_IDLE);
    assign cap_stb = sel_wr && !wr_prev_q;
    assign wr_prev_d = sel_wr;

    // Lowest active lane wins; a single-byte write has exactly one
    always_comb begin
        cap_byte = data_s2_q[BYTE_W-1:0];
        for (int i = LANES - 1; i >= 0; i--) begin
            if (!wr_s2_q[i]) begin
                cap_byte = data_s2_q[i*BYTE_W +: BYTE_W];
            end
        end
    end

    // ****************************************
    // Capture holding stage
    // ****************************************
    logic              pend_q, pend_d;                // Byte waiting for the FIFO
    logic [BYTE_W-1:0] pbyte_q, pbyte_d;
    logic              f_in_ready;
    logic              f_valid;
    logic [BYTE_W-1:0] f_data;
    logic              pop;

    // A full FIFO holds the byte here; a second write meanwhile replaces it
    always_comb begin
        pend_d  = pend_q && !f_in_ready;
        pbyte_d = pbyte_q;
        if (cap_stb) begin
            pend_d  = 1'b1;
            pbyte_d = cap_byte;
        end
    end

    // Registers
    always_ff @(posedge clock) begin
        if (reset) begin
            pend_q    <= 1'b0;
            pbyte_q   <= '0;
            wr_prev_q <= 1'b0;
        end else begin
            pend_q    <= pend_d;
            pbyte_q   <= pbyte_d;
            wr_prev_q <= wr_prev_d;
        end
    end

    mtp_fifo #(
        .WIDTH (BYTE_W),
        .DEPTH (FDEPTH)
    ) u_fifo (
        .clock     (clock),
        .reset     (reset),
        .in_valid  (pend_q),
        .in_ready  (f_in_ready),
        .in_data   (pbyte_q),
        .out_valid (f_valid),
        .out_ready (pop),
        .out_data  (f_data)
    );

    // ****************************************
    // Message engine
    // ****************************************
    mtp_state_type     state_q, state_d;              // Engine state
    logic [BYTE_W-1:0] buf_q [DEPTH];                 // Message buffer
    logic [BYTE_W-1:0] buf_d [DEPTH];
    logic [CW-1:0]     cnt_q, cnt_d;                  // Characters held
    logic [CW-1:0]     rd_q, rd_d;                    // Emit index
    logic              xpend_q, xpend_d;              // Exit after this emission
    logic              exit_q, exit_d;                // Sticky failure exit
    logic              cv_q, cv_d;                    // Character strobe
    logic [BYTE_W-1:0] ch_q, ch_d;                    // Character out
    logic              mv_q, mv_d;                    // Message done strobe
    logic [CW-1:0]     ml_q, ml_d;                    // Message length
    logic              printable;

    assign printable = (f_data >= CHR_LO) && (f_data <= CHR_HI);

    // The drain stalls during emission, so bursts back up into the FIFO
    always_comb begin
        state_d = state_q;
        buf_d   = buf_q;
        cnt_d   = cnt_q;
        rd_d    = rd_q;
        xpend_d = xpend_q;
        exit_d  = exit_q;
        cv_d    = 1'b0;
        ch_d    = ch_q;
        mv_d    = 1'b0;
        ml_d    = ml_q;
        pop     = 1'b0;
        case (state_q)
            MTP_ST_IDLE: begin
                if (xpend_q) begin
                    // Exit deferred behind a flushed message
                    exit_d  = 1'b1;
                    xpend_d = 1'b0;
                end else if (f_valid) begin
                    pop = 1'b1;
                    if (f_data == CHR_EXIT) begin
                        if (cnt_q == '0) begin
                            exit_d = 1'b1;
                        end else begin
                            xpend_d = 1'b1;
                            rd_d    = '0;
                            state_d = MTP_ST_EMIT;
                        end
                    end else if (f_data == CHR_LF || f_data == CHR_CR) begin
                        rd_d    = '0;
                        state_d = MTP_ST_EMIT;
                    end else if (printable) begin
                        buf_d[cnt_q] = f_data;
                        cnt_d        = CW'(cnt_q + 1'b1);
                        if (cnt_q == LASTC) begin
                            rd_d    = '0;
                            state_d = MTP_ST_EMIT;
                        end
                    end
                    // Other control codes are dropped
                end
            end
            MTP_ST_EMIT: begin
                if (rd_q == cnt_q) begin
                    mv_d    = 1'b1;
                    ml_d    = cnt_q;
                    cnt_d   = '0;
                    state_d = MTP_ST_IDLE;
                end else begin
                    // One stream feeds the display output
                    cv_d = 1'b1;
                    ch_d = buf_q[rd_q];
                    rd_d = CW'(rd_q + 1'b1);
                end
            end
            default: begin
                state_d = MTP_ST_IDLE;
            end
        endcase
    end

    // Registers
    always_ff @(posedge clock) begin
        if (reset) begin
            state_q <= MTP_ST_IDLE;
            cnt_q   <= '0;
            rd_q    <= '0;
            xpend_q <= 1'b0;
            exit_q  <= 1'b0;
            cv_q    <= 1'b0;
            ch_q    <= '0;
            mv_q    <= 1'b0;
            ml_q    <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                buf_q[i] <= '0;
            end
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            rd_q    <= rd_d;
            xpend_q <= xpend_d;
            exit_q  <= exit_d;
            cv_q    <= cv_d;
            ch_q    <= ch_d;
            mv_q    <= mv_d;
            ml_q    <= ml_d;
            buf_q   <= buf_d;
        end
    end

    assign out_char_valid = cv_q;
    assign out_char       = ch_q;
    assign msg_done       = mv_q;
    assign msg_len        = ml_q;
    assign exit_fail      = exit_q;

    // ****************************************
    // Assertions
    // ****************************************
    AST_CAPTURE_SELECTED: assert property (@(posedge clock) disable iff (reset)
        cap_stb |-> !cs_s2_q[CS_LINE] && !$past(sel_wr))
        else $error("Capture without chip select two");
    AST_LANE_LOW: assert property (@(posedge clock) disable iff (reset)
        cap_stb && !wr_s2_q[0] |-> cap_byte == data_s2_q[7:0])
        else $error("Lane zero byte not taken from low bits");
    AST_LANE_HIGH: assert property (@(posedge clock) disable iff (reset)
        cap_stb && wr_s2_q == 4'h7 |-> cap_byte == data_s2_q[31:24])
        else $error("Lane three byte not taken from high bits");
    AST_EXIT_EMPTY: assert property (@(posedge clock) disable iff (reset)
        state_q == MTP_ST_IDLE && !xpend_q && pop && f_data == CHR_EXIT && cnt_q == '0
        |=> exit_fail)
        else $error("Exit on empty buffer not flagged");
    AST_EXIT_STICKY: assert property (@(posedge clock) disable iff (reset)
        exit_fail |=> exit_fail)
        else $error("Exit flag dropped without reset");
    AST_FULL_EMIT: assert property (@(posedge clock) disable iff (reset)
        state_q == MTP_ST_IDLE && pop && printable && cnt_q == LASTC
        |=> state_q == MTP_ST_EMIT && cnt_q == CW'(DEPTH))
        else $error("Full buffer not emitted");
    AST_STORE_COUNT: assert property (@(posedge clock) disable iff (reset)
        state_q == MTP_ST_IDLE && !xpend_q && pop && printable && cnt_q < LASTC
        |=> cnt_q == CW'($past(cnt_q) + 1'b1) && state_q == MTP_ST_IDLE)
        else $error("Printable character not stored");
    AST_TERM_EMIT: assert property (@(posedge clock) disable iff (reset)
        state_q == MTP_ST_IDLE && !xpend_q && pop && (f_data == CHR_LF || f_data == CHR_CR)
        |=> state_q == MTP_ST_EMIT && !pop)
        else $error("Terminator did not start emission");
    AST_DONE_CLEARS: assert property (@(posedge clock) disable iff (reset)
        msg_done |-> cnt_q == '0 ##1 !msg_done)
        else $error("Done strobe not single or buffer not cleared");
    AST_STREAM_LEN: assert property (@(posedge clock) disable iff (reset)
        out_char_valid && state_q == MTP_ST_EMIT && rd_q == cnt_q |=> msg_done)
        else $error("Character stream not closed by done strobe");

endmodule : mtp_message_port

`default_nettype wire

// *** mtp_bus_writer.sv ***
// Behavioural model of the static memory interface that writes into the port
`timescale 1ns/1ps
`default_nettype none

module mtp_bus_writer
    import mtp_pkg::*;
(
    input  wire logic              clock,
    output logic      [DATA_W-1:0] ext_data_bus,
    output logic      [LANES-1:0]  ext_chip_sel_n,
    output logic      [LANES-1:0]  ext_byte_wr_n
);

    // Bus idle at time zero: nothing selected, nothing strobed
    initial begin
        ext_data_bus   = 32'h0000_0000;
        ext_chip_sel_n = STRB_IDLE;
        ext_byte_wr_n  = STRB_IDLE;
    end

    // One write on the given strobes: data set up two clocks ahead, strobes held three clocks
    task automatic write_word(input logic [3:0] cs_n, input logic [3:0] wr_n,
                              input logic [31:0] data, input int gap);
        ext_data_bus = data;
        repeat (2) @(negedge clock);
        ext_chip_sel_n = cs_n;
        ext_byte_wr_n  = wr_n;
        repeat (3) @(negedge clock);
        ext_chip_sel_n = STRB_IDLE;
        ext_byte_wr_n  = STRB_IDLE;
        @(negedge clock);
        // No keeper on the bus: show the inverse so a late sample cannot match
        ext_data_bus = ~data;
        repeat (gap) @(negedge clock);
    endtask : write_word

endmodule : mtp_bus_writer
`default_nettype wire

// *** mtp_message_port_tb.sv ***
// Self-checking testbench for the message port
`timescale 1ns/1ps
`default_nettype none

module mtp_message_port_tb
    import mtp_pkg::*;
;
    logic              clock;           // 10 MHz bench clock
    logic              reset;           // Synchronous reset, active high
    logic [DATA_W-1:0] ext_data_bus;    // Bus driven by the writer model
    logic [LANES-1:0]  ext_chip_sel_n;  // Active low selects
    logic [LANES-1:0]  ext_byte_wr_n;   // Active low byte strobes
    logic              out_char_valid;  // Emitted character strobe
    logic [BYTE_W-1:0] out_char;        // Emitted character
    logic              msg_done;        // End of message strobe
    logic [6:0]        msg_len;         // Message length
    logic              exit_fail;       // Program exit flag
    int                error_cnt;       // Mismatches seen
    int                total_checks;    // Comparisons made
    int                cycles;          // Watchdog count
    int                exp_msgs;        // Messages the model emitted
    int                got_msgs;        // Messages the design emitted
    int                mon_n;           // Length popped by the monitor
    logic              exp_exit;        // Model exit flag
    logic [7:0]        buf_q[$];        // Model message buffer
    logic [7:0]        exp_chars[$];    // Expected emitted text
    int                exp_lens[$];     // Expected message lengths
    logic [7:0]        got_q[$];        // Text of the message in flight

    mtp_message_port #(.DEPTH(BUF_DEPTH), .FDEPTH(FIFO_DEPTH)) u_mtp_message_port (
        .clock          (clock),
        .reset          (reset),
        .ext_data_bus   (ext_data_bus),
        .ext_chip_sel_n (ext_chip_sel_n),
        .ext_byte_wr_n  (ext_byte_wr_n),
        .out_char_valid (out_char_valid),
        .out_char       (out_char),
        .msg_done       (msg_done),
        .msg_len        (msg_len),
        .exit_fail      (exit_fail)
    );

    mtp_bus_writer u_mtp_bus_writer (
        .clock          (clock),
        .ext_data_bus   (ext_data_bus),
        .ext_chip_sel_n (ext_chip_sel_n),
        .ext_byte_wr_n  (ext_byte_wr_n)
    );

    // ****************************************
    // Clock, checks and closing report
    // ****************************************
    initial clock = 1'b0;
    always #50 clock = ~clock;

    task automatic check(input logic ok, input string what);
        total_checks++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("ERROR at %0t: %s", $time, what);
        end
    endtask : check

    task automatic test_done();
        $display("Checks made: %0d, mismatches: %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    // Watchdog: the whole run needs well under this many cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            error_cnt++;
            $display("ERROR at %0t: watchdog expired", $time);
            test_done();
        end
    end

    // Gather emitted text at the falling edge, where registered outputs have settled
    always @(negedge clock) begin
        if (reset) begin
            got_q.delete();
        end else begin
            if (!exp_exit && exit_fail !== 1'b0) check(1'b0, "exit raised early");
            if (out_char_valid === 1'b1) got_q.push_back(out_char);
            if (msg_done === 1'b1) begin
                got_msgs++;
                mon_n = (exp_lens.size() > 0) ? exp_lens.pop_front() : -1;
                check(msg_len === 7'(mon_n) && got_q.size() == mon_n, "length");
                foreach (got_q[i]) check(got_q[i] === exp_chars[i], "text");
                repeat (mon_n) void'(exp_chars.pop_front());
                got_q.delete();
            end
        end
    end

    // ****************************************
    // Reference model and bus stimulus
    // ****************************************
    function automatic void flush();
        exp_lens.push_back(buf_q.size());
        foreach (buf_q[i]) exp_chars.push_back(buf_q[i]);
        buf_q.delete();
        exp_msgs++;
    endfunction : flush

    // Expected reaction to one accepted byte
    function automatic void model_char(input logic [7:0] c);
        if (c == CHR_EXIT) begin
            if (buf_q.size() > 0) flush();
            exp_exit = 1'b1;
        end else if (c == CHR_LF || c == CHR_CR) begin
            flush();
        end else if (c >= CHR_LO && c <= CHR_HI) begin
            buf_q.push_back(c);
            if (buf_q.size() == BUF_DEPTH) flush();
        end
    endfunction : model_char

    // Wait for outstanding messages, bounded
    task automatic settle();
        int n;
        n = 0;
        repeat (12) @(negedge clock);
        while (got_msgs != exp_msgs && n < 300) begin
            @(negedge clock);
            n++;
        end
        check(got_msgs == exp_msgs, "message count");
    endtask : settle

    // Model first, since the design may answer before the write returns
    task automatic put(input logic [3:0] cs_n, input logic [3:0] wr_n,
                       input logic [31:0] data, input bit quick);
        int lane;
        lane = 0;
        while (lane < LANES && wr_n[lane]) lane++;
        if (!cs_n[CS_LINE] && lane < LANES) model_char(data[lane*8 +: 8]);
        u_mtp_bus_writer.write_word(cs_n, wr_n, data, quick ? 1 : $urandom_range(4, 1));
        if (!quick) settle();
    endtask : put

    task automatic put_char(input logic [7:0] c, input bit quick);
        int          lane;
        logic [31:0] data;
        lane = $urandom_range(3, 0);
        data = $urandom;
        data[lane*8 +: 8] = c;
        put(~(4'h1 << CS_LINE), ~(4'h1 << lane), data, quick);
    endtask : put_char

    task automatic put_str(input string s);
        foreach (s[i]) put_char(s[i], 1'b0);
    endtask : put_str

    task automatic do_reset();
        reset = 1'b1;
        repeat (2) @(negedge clock);
        reset = 1'b0;
        buf_q.delete();
        exp_exit = 1'b0;
        repeat (2) @(negedge clock);
    endtask : do_reset

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [31:0] data;
        logic [7:0]  c;
        reset = 1'b1;
        exp_exit = 1'b0;
        void'($urandom(77));
        repeat (8) @(negedge clock);
        reset = 1'b0;
        repeat (2) @(negedge clock);
        // Short line, then CR LF giving two empty messages
        put_str("Hi");
        put_char(CHR_LF, 1'b0);
        put_char(CHR_CR, 1'b0);
        put_char(CHR_LF, 1'b0);
        $display("Test terminators done");
        // Every lane, then several strobes low at once
        for (int l = 0; l < LANES; l++) begin
            data = $urandom;
            data[l*8 +: 8] = 8'h41 + 8'(l);
            put(~(4'h1 << CS_LINE), ~(4'h1 << l), data, 1'b0);
        end
        put(~(4'h1 << CS_LINE), 4'h0, 32'h4443_4241, 1'b0);
        put(~(4'h1 << CS_LINE), 4'h9, 32'h4443_4241, 1'b0);
        put_char(CHR_LF, 1'b0);
        $display("Test lanes done");
        // Foreign selects and a select without strobes are ignored
        for (int l = 0; l < LANES; l++) begin
            if (l != CS_LINE) put(~(4'h1 << l), 4'h0, 32'h5A5A_5A5A, 1'b0);
        end
        put(~(4'h1 << CS_LINE), STRB_IDLE, 32'h5A5A_5A5A, 1'b0);
        put_char(CHR_LF, 1'b0);
        $display("Test selects done");
        // Random codes, control codes included
        repeat (40) begin
            c = 8'($urandom_range(255, 0));
            if (c == CHR_EXIT) c = 8'h01;
            put_char(c, 1'b0);
        end
        put_char(CHR_LF, 1'b0);
        $display("Test random done");
        // Full buffer; more writes land in the FIFO during emission
        repeat (BUF_DEPTH - 1) put_char(8'($urandom_range(126, 32)), 1'b0);
        put_char(8'h5A, 1'b1);
        repeat (FIFO_DEPTH) put_char(8'($urandom_range(126, 32)), 1'b1);
        settle();
        put_char(CHR_LF, 1'b0);
        $display("Test full buffer done");
        // Reset drops pending text
        put_str("xy");
        do_reset();
        put_char(CHR_LF, 1'b0);
        $display("Test reset done");
        // Exit with pending text, then on an empty buffer
        put_str("ab");
        put_char(CHR_EXIT, 1'b0);
        repeat (4) @(negedge clock);
        check(exit_fail === 1'b1, "exit after text");
        do_reset();
        check(exit_fail === 1'b0, "exit cleared");
        put_char(CHR_EXIT, 1'b0);
        repeat (4) @(negedge clock);
        check(exit_fail === 1'b1, "exit on empty");
        $display("Test exit done");
        test_done();
    end

endmodule : mtp_message_port_tb
`default_nettype wire
